// File: include/rtc_pkg.sv
// Constants for the real time counter block.
// Assumes a single instruction-cycle clock domain.
package rtc_pkg;
    localparam int unsigned CNT_W      = 8;
    localparam int unsigned PRE_W      = 8;
    localparam int unsigned RATE_W     = 3;
    localparam int unsigned CFG_W      = 8;
    localparam int unsigned CFG_SRC    = 5;
    localparam int unsigned CFG_EDGE   = 4;
    localparam int unsigned CFG_ASSIGN = 3;
    localparam int unsigned CFG_IEN    = 6;
    localparam int unsigned RATE_LSB   = 0;
    localparam logic [CNT_W-1:0] CNT_MAX   = 8'hff;
    localparam logic [CNT_W-1:0] CNT_RST   = 8'h00;
    localparam logic [PRE_W-1:0] PRE_RST   = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
    localparam logic [PRE_W-1:0] PRE_ONE   = 8'h01;
endpackage

// File: design/rtc_counter.sv
// Real time counter with shared prescaler and pin event source.
// Assumes count pin and watchdog tick are synchronous inputs on sys_clk_i,
// which is the instruction-cycle clock.
`timescale 1ns/100ps
module rtc_counter
(
    input  wire logic                      sys_clk_i,        // Instr clock
    input  wire logic                      arst_n_i,         // Async reset
    input  wire logic [rtc_pkg::CFG_W-1:0] timer_config_i,   // Config bits
    input  wire logic                      count_pin_i,      // Ext count pin
    input  wire logic                      watchdog_tick_i,  // Watchdog tick
    input  wire logic                      count_load_i,     // Software write
    input  wire logic [rtc_pkg::CNT_W-1:0] count_load_val_i, // Write data
    output logic [rtc_pkg::CNT_W-1:0]      real_time_counter_o, // Count
    output logic                           irq_o,            // Rollover pulse
    output logic                           watchdog_post_o   // Watchdog tick, postscaled when prescaler assigned
);
    logic [rtc_pkg::CNT_W-1:0]  cnt_q;
    logic [rtc_pkg::PRE_W-1:0]  pre_q;
    logic [rtc_pkg::PRE_W-1:0]  pre_d;
    logic                       pin_q;
    logic                       pin_prev_q;
    logic                       pin_vld_q;
    logic                       pin_hist_vld_q;
    logic                       irq_q;
    logic                       wdp_q;
    logic                       src_ext;
    logic                       fall_sel;
    logic                       prescaler_assign_select;
    logic [rtc_pkg::RATE_W-1:0] prescaler_rate_select;
    logic                       edge_hit;
    logic                       pre_in;
    logic                       pre_tap;
    logic                       pre_tap_q;
    logic                       pre_pulse;
    logic                       cnt_tick;

    // All checks below share the one instruction clock and reset
    default clocking chk_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    assign src_ext  = timer_config_i[rtc_pkg::CFG_SRC];
    assign fall_sel = timer_config_i[rtc_pkg::CFG_EDGE];
    assign prescaler_assign_select = timer_config_i[rtc_pkg::CFG_ASSIGN];
    assign prescaler_rate_select =
        timer_config_i[rtc_pkg::RATE_LSB +: rtc_pkg::RATE_W];

    // Pin comes in as synchronous; one register stage gives edge history.
    // No edge is taken until two real samples are in, so a pin that idles
    // high when reset lifts is not mistaken for a rising edge.
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_q          <= 1'b0;
            pin_prev_q     <= 1'b0;
            pin_vld_q      <= 1'b0;
            pin_hist_vld_q <= 1'b0;
        end
        else
        begin
            pin_q          <= count_pin_i;
            pin_prev_q     <= pin_q;
            pin_vld_q      <= 1'b1;
            pin_hist_vld_q <= pin_vld_q;
        end
    end

    assign edge_hit = pin_hist_vld_q
                      & (fall_sel ? (pin_prev_q & ~pin_q)
                                  : (~pin_prev_q & pin_q));

    // Prescaler input: counter source, or watchdog tick when reassigned
    always_comb
    begin
        if (prescaler_assign_select)
            pre_in = watchdog_tick_i;
        else if (src_ext)
            pre_in = edge_hit;
        else
            pre_in = 1'b1;
    end

    assign pre_d   = pre_in ? pre_q + rtc_pkg::PRE_ONE : pre_q;
    assign pre_tap = pre_q[prescaler_rate_select];
    // Falling edge of the selected tap divides by 2^(rate+1)
    assign pre_pulse = pre_tap_q & ~pre_tap;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pre_q     <= rtc_pkg::PRE_RST;
            pre_tap_q <= 1'b0;
        end
        else
        begin
            pre_q     <= pre_d;
            pre_tap_q <= pre_tap;
        end
    end

    always_comb
    begin
        if (prescaler_assign_select)
            cnt_tick = src_ext ? edge_hit : 1'b1;
        else
            cnt_tick = pre_pulse;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt_q <= rtc_pkg::CNT_RST;
        else if (count_load_i)
            cnt_q <= count_load_val_i;
        else if (cnt_tick)
            cnt_q <= cnt_q + rtc_pkg::CNT_ONE;
    end

    // Interrupt is a pulse only: nothing is latched for software
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_q <= 1'b0;
        else
            irq_q <= !count_load_i && cnt_tick
                     && cnt_q == rtc_pkg::CNT_MAX
                     && timer_config_i[rtc_pkg::CFG_IEN];
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wdp_q <= 1'b0;
        else
            wdp_q <= prescaler_assign_select ? pre_pulse
                                             : watchdog_tick_i;
    end

    assign real_time_counter_o = cnt_q;
    assign irq_o               = irq_q;
    assign watchdog_post_o     = wdp_q;

    wrap_irq_a: assert property (
        (!count_load_i && cnt_tick && cnt_q == rtc_pkg::CNT_MAX
         && timer_config_i[rtc_pkg::CFG_IEN])
        |=> (irq_o && cnt_q == rtc_pkg::CNT_RST))
        else $error("rollover did not raise interrupt");

    irq_zero_a: assert property (
        irq_o |-> real_time_counter_o == rtc_pkg::CNT_RST)
        else $error("interrupt without the count at zero");

    irq_gate_a: assert property (
        !timer_config_i[rtc_pkg::CFG_IEN] |=> !irq_o)
        else $error("interrupt raised while disabled");

    no_pend_a: assert property (
        irq_o |=> !irq_o)
        else $error("interrupt held like a pending flag");

    sequence int_run_s;
        !src_ext && prescaler_assign_select && !count_load_i;
    endsequence
    int_count_a: assert property (
        int_run_s |=> cnt_q == $past(cnt_q) + rtc_pkg::CNT_ONE)
        else $error("internal mode did not count every cycle");

    ext_hold_a: assert property (
        (src_ext && prescaler_assign_select && !count_load_i && !edge_hit)
        |=> cnt_q == $past(cnt_q))
        else $error("external mode counted without an edge");

    // A pin change reaches the edge detector one cycle after it is sampled
    sequence pin_rise_s;
        !count_pin_i ##1 (count_pin_i && !fall_sel && pin_hist_vld_q);
    endsequence
    sequence pin_fall_s;
        count_pin_i ##1 (!count_pin_i && fall_sel && pin_hist_vld_q);
    endsequence

    rise_edge_a: assert property (
        pin_rise_s |=> edge_hit)
        else $error("rising pin edge missed");

    fall_edge_a: assert property (
        pin_fall_s |=> edge_hit)
        else $error("falling pin edge missed");

    edge_sel_a: assert property (
        (fall_sel && $past(pin_q) && !pin_q) |-> edge_hit)
        else $error("falling edge not detected");

    pre_hold_a: assert property (
        (!prescaler_assign_select && !count_load_i && !pre_pulse)
        |=> cnt_q == $past(cnt_q))
        else $error("counter moved without prescaler pulse");

    pre_feed_a: assert property (
        (prescaler_assign_select && !watchdog_tick_i)
        |=> pre_q == $past(pre_q))
        else $error("prescaler moved without a watchdog tick");

    wdt_post_a: assert property (
        !prescaler_assign_select
        |=> watchdog_post_o == $past(watchdog_tick_i))
        else $error("watchdog tick not passed through");

    one_step_a: assert property (
        !count_load_i
        |=> (cnt_q == $past(cnt_q)
             || cnt_q == $past(cnt_q) + rtc_pkg::CNT_ONE))
        else $error("counter moved more than one step");

    load_win_a: assert property (
        count_load_i |=> cnt_q == $past(count_load_val_i))
        else $error("software load did not take effect");
endmodule

// File: sim/rtc_far_end.sv
// Far side model: external count pin and watchdog tick source.
// Assumes it is clocked by the instruction clock; drives 1 ns after edges.
`timescale 1ns/100ps
module rtc_far_end
(
    input  wire logic sys_clk_i, // Clock
    input  wire logic run_i,     // Random activity on
    input  wire logic clr_i,     // Clear counts, park pin low
    output logic      pin_o,     // Count pin
    output logic      tick_o,    // Watchdog tick pulse
    output int        rise_o,    // Rising edges made
    output int        fall_o,    // Falling edges made
    output int        tick_n_o   // Ticks made
);
    logic nx;
    initial
    begin
        pin_o = 1'b0;
        tick_o = 1'b0;
    end
    always @(posedge sys_clk_i)
    begin
        #1;
        nx = run_i ? 1'($urandom) : pin_o;
        tick_o = run_i && !clr_i && ($urandom % 4 == 0);
        if (clr_i)
        begin
            // Parked low so no edge is left over for the next run
            nx = 1'b0;
            rise_o = 0;
            fall_o = 0;
            tick_n_o = 0;
        end
        else
        begin
            rise_o += int'(nx && !pin_o);
            fall_o += int'(!nx && pin_o);
            tick_n_o += int'(tick_o);
        end
        pin_o = nx;
    end
endmodule

// File: sim/rtc_counter_tb.sv
// Bench for the real time counter: reference counts against the design.
// Assumes rtc_far_end drives the count pin and the watchdog tick.
`timescale 1ns/100ps
module rtc_counter_tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] cfg = 8'h00;
    logic       ld = 1'b0;
    logic [7:0] lv = 8'h00;
    logic       run = 1'b0;
    logic       pin, tick, irq, post, lq, ldm, e_irq;
    logic [7:0] cnt, prv, c0, ev;
    int         rise, fall, tn, n_fail, compares, k, i, r, posts;
    always #5 clk = ~clk;
    rtc_far_end far (.sys_clk_i(clk), .run_i(run), .clr_i(~rst_n),
        .pin_o(pin), .tick_o(tick), .rise_o(rise), .fall_o(fall),
        .tick_n_o(tn));
    rtc_counter dut (.sys_clk_i(clk), .arst_n_i(rst_n),
        .timer_config_i(cfg), .count_pin_i(pin), .watchdog_tick_i(tick),
        .count_load_i(ld), .count_load_val_i(lv),
        .real_time_counter_o(cnt), .irq_o(irq), .watchdog_post_o(post));
    task automatic cmp_val(string nm, logic [7:0] e, logic [7:0] s);
        compares++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic cmp_cnt(string nm, int e, int s);
        compares++;
        if (s != e)
        begin
            n_fail++;
            $display("CHECK FAILED %s exp %0d got %0d", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic run_cfg();
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        // Pin stays parked one more edge while the edge history fills
        @(posedge clk);
        #1;
        run = 1'b1;
        posts = 0;
        ldm = cfg[3] && !cfg[5];
        for (k = 0; k < 600; k++)
        begin
            prv = cnt;
            lq = ld;
            @(posedge clk);
            #1;
            // A load in the wrap cycle wins and suppresses the request
            e_irq = cfg[6] && prv == 8'hff && cnt == 8'h00 && !lq;
            if (k > 1)
                cmp_val("irq", {7'h00, e_irq}, {7'h00, irq});
            posts += int'(post === 1'b1);
            if (!cfg[5] && k == 40)
                c0 = cnt;
            if (!cfg[5] && k == (cfg[3] ? 140 : 552))
            begin
                ev = cfg[3] ? 8'h64 : 8'(512 >> (r + 1));
                cmp_val("delta", ev, cnt - c0);
            end
            if (ldm && k == 301)
                cmp_val("load", lv, cnt);
            if (ldm && k == 302)
                cmp_val("after load", lv + 8'h01, cnt);
            ld = ldm && k == 300;
            if (k == 300)
                lv = 8'($urandom);
            if (k == 580)
                run = 1'b0;
        end
        cmp_cnt("wd post", cfg[3] ? tn >> (r + 1) : tn, posts);
        ev = 8'((cfg[4] ? fall : rise) >> (cfg[3] ? 0 : r + 1));
        if (cfg[5])
            cmp_val("pin count", ev, cnt);
    endtask
    initial
    begin
        void'($urandom(71));
        for (i = 0; i < 16; i++)
        begin
            // Every source, edge, assignment, enable and rate code
            r = (i * 3) % 8;
            cfg = {1'b0, i[3], i[0], i[2], i[1], r[2:0]};
            run_cfg();
        end
        end_of_test();
    end
    initial
    begin
        #300000;
        n_fail++;
        end_of_test();
    end
endmodule
